// *** include/fgp_pkg.sv ***
// Shared constants, access selectors and the access carrier for the fast GPIO port
package fgp_pkg;

    // Port width and lane layout
    localparam int FGP_DATA_W = 32;
    localparam int FGP_LANES = 4;
    localparam int FGP_LANE_W = 8;

    // Reset value and byte lane strobes
    localparam logic [31:0] FGP_ZERO = 32'h0000_0000;
    localparam logic [3:0] FGP_ALL_LANES = 4'hF;
    localparam logic [3:0] FGP_LANE0 = 4'h1;

    // Register selectors of the access port
    typedef enum logic [2:0]
    {
        FGP_SEL_DIR,
        FGP_SEL_MASK,
        FGP_SEL_VAL,
        FGP_SEL_SET,
        FGP_SEL_CLR,
        FGP_SEL_RISE,
        FGP_SEL_FALL,
        FGP_SEL_STAT
    } fgp_sel_t;

    // One access: write or read strobe, selector, byte lanes and data
    typedef struct packed
    {
        logic wr;
        logic rd;
        fgp_sel_t sel;
        logic [FGP_LANES-1:0] be;
        logic [FGP_DATA_W-1:0] wdata;
    } fgp_acc_t;

endpackage

// *** verilog/fgp_port.sv ***
// Fast general purpose I/O port with direction, masked access and edge events
`timescale 1ns/1ns

module fgp_port
(
    input wire logic ref_clk_i,                                 // System clock
    input wire logic rst_b_i,                                   // Asynchronous reset, active low
    input wire fgp_pkg::fgp_acc_t acc_i,                        // Register access request
    output logic [fgp_pkg::FGP_DATA_W-1:0] rdata_o,             // Read data, one cycle after rd
    input wire logic [fgp_pkg::FGP_DATA_W-1:0] pin_in_i,        // Pin levels from the pads
    output logic [fgp_pkg::FGP_DATA_W-1:0] pin_out_o,           // Output latch to the pads
    output logic [fgp_pkg::FGP_DATA_W-1:0] pin_oe_o,            // Pad driver enable, high drives
    output logic irq_o,                                         // Port interrupt request
    output logic wake_o                                         // Wake request, works clockless
);
    import fgp_pkg::*;

    // Expand byte strobes into a bit mask
    function automatic logic [FGP_DATA_W-1:0] lane_bits(input logic [FGP_LANES-1:0] be);
        logic [FGP_DATA_W-1:0] m;
        m = FGP_ZERO;
        for (int k = 0; k < FGP_LANES; k++)
        begin
            m[k*FGP_LANE_W +: FGP_LANE_W] = {FGP_LANE_W{be[k]}};
        end
        return m;
    endfunction

    // Is this a write to the given selector
    function automatic logic wr_to(input fgp_acc_t a, input fgp_sel_t s);
        return a.wr && (a.sel == s);
    endfunction

    logic [FGP_DATA_W-1:0] dir_r, dir_nxt;
    logic [FGP_DATA_W-1:0] mask_r, mask_nxt;
    logic [FGP_DATA_W-1:0] out_r, out_nxt;
    logic [FGP_DATA_W-1:0] rise_en_r, rise_en_nxt;
    logic [FGP_DATA_W-1:0] fall_en_r, fall_en_nxt;
    logic [FGP_DATA_W-1:0] stat_r, stat_nxt;
    logic [FGP_DATA_W-1:0] rdata_r, rdata_nxt;
    logic irq_r, irq_nxt;
    logic [FGP_DATA_W-1:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_val_r, pin_val_nxt;
    wire [FGP_DATA_W-1:0] rise_tgl;
    wire [FGP_DATA_W-1:0] fall_tgl;
    logic [FGP_DATA_W-1:0] rt_s1_r, rt_s2_r, rt_s3_r, rise_seen_r, rise_seen_nxt;
    logic [FGP_DATA_W-1:0] ft_s1_r, ft_s2_r, ft_s3_r, fall_seen_r, fall_seen_nxt;
    wire [FGP_DATA_W-1:0] lanes;
    wire [FGP_DATA_W-1:0] port_bits;
    wire [FGP_DATA_W-1:0] edge_ev;
    wire [FGP_DATA_W-1:0] stat_clr;

    // Writable bits of this access
    // lane selection
    assign lanes = lane_bits(acc_i.be);
    assign port_bits = lanes & ~mask_r;

    // Direction and configuration registers take the addressed lanes only
    // direction update
    assign dir_nxt = wr_to(acc_i, FGP_SEL_DIR) ? ((dir_r & ~lanes) | (acc_i.wdata & lanes)) : dir_r;
    assign mask_nxt = wr_to(acc_i, FGP_SEL_MASK) ? ((mask_r & ~lanes) | (acc_i.wdata & lanes)) : mask_r;
    assign rise_en_nxt = wr_to(acc_i, FGP_SEL_RISE) ? ((rise_en_r & ~lanes) | (acc_i.wdata & lanes)) : rise_en_r;
    assign fall_en_nxt = wr_to(acc_i, FGP_SEL_FALL) ? ((fall_en_r & ~lanes) | (acc_i.wdata & lanes)) : fall_en_r;

    // Output latch: value write, atomic set and atomic clear
    // set and clear
    always_comb
    begin
        out_nxt = out_r;
        case (acc_i.sel)
            FGP_SEL_VAL: out_nxt = acc_i.wr ? ((out_r & ~port_bits) | (acc_i.wdata & port_bits)) : out_r;
            FGP_SEL_SET: out_nxt = acc_i.wr ? (out_r | (acc_i.wdata & port_bits)) : out_r;
            FGP_SEL_CLR: out_nxt = acc_i.wr ? (out_r & ~(acc_i.wdata & port_bits)) : out_r;
            default: out_nxt = out_r;
        endcase
    end

    // Read mux; reading value shows the live pins, masked bits read as zero
    // latch and pin read-back
    always_comb
    begin
        rdata_nxt = rdata_r;
        if (acc_i.rd)
        begin
            case (acc_i.sel)
                FGP_SEL_DIR: rdata_nxt = dir_r;
                FGP_SEL_MASK: rdata_nxt = mask_r;
                FGP_SEL_VAL: rdata_nxt = pin_val_r & ~mask_r;
                FGP_SEL_SET: rdata_nxt = out_r & ~mask_r;
                FGP_SEL_CLR: rdata_nxt = out_r & ~mask_r;
                FGP_SEL_RISE: rdata_nxt = rise_en_r;
                FGP_SEL_FALL: rdata_nxt = fall_en_r;
                FGP_SEL_STAT: rdata_nxt = stat_r;
                default: rdata_nxt = FGP_ZERO;
            endcase
        end
    end

    // Bus registers; one cycle per access, no wait states
    // all pins inputs at reset
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            dir_r <= FGP_ZERO;
            mask_r <= FGP_ZERO;
            out_r <= FGP_ZERO;
            rise_en_r <= FGP_ZERO;
            fall_en_r <= FGP_ZERO;
            rdata_r <= FGP_ZERO;
        end
        else
        begin
            dir_r <= dir_nxt;
            mask_r <= mask_nxt;
            out_r <= out_nxt;
            rise_en_r <= rise_en_nxt;
            fall_en_r <= fall_en_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // Edge capture on the pin itself; the clock may be stopped meanwhile.
    // A toggle per edge type keeps each capture single-clocked.
    // clockless capture
    genvar gi;
    generate
        for (gi = 0; gi < FGP_DATA_W; gi++)
        begin : g_edge
            // One local flop per pin and edge type, so every bit has a single driver
            logic rise_t_r;
            logic fall_t_r;
            always_ff @(posedge pin_in_i[gi] or negedge rst_b_i)
            begin
                if (!rst_b_i)
                    rise_t_r <= 1'b0;
                else if (rise_en_r[gi])
                    rise_t_r <= ~rise_t_r;
            end
            always_ff @(negedge pin_in_i[gi] or negedge rst_b_i)
            begin
                if (!rst_b_i)
                    fall_t_r <= 1'b0;
                else if (fall_en_r[gi])
                    fall_t_r <= ~fall_t_r;
            end
            assign rise_tgl[gi] = rise_t_r;
            assign fall_tgl[gi] = fall_t_r;
        end
    endgenerate

    // Three-stage synchronisers; a change counts when stages two and three agree
    assign pin_val_nxt = (~(pin_s2_r ^ pin_s3_r) & pin_s3_r) | ((pin_s2_r ^ pin_s3_r) & pin_val_r);
    assign rise_seen_nxt = (~(rt_s2_r ^ rt_s3_r) & rt_s3_r) | ((rt_s2_r ^ rt_s3_r) & rise_seen_r);
    assign fall_seen_nxt = (~(ft_s2_r ^ ft_s3_r) & ft_s3_r) | ((ft_s2_r ^ ft_s3_r) & fall_seen_r);

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            pin_s1_r <= FGP_ZERO;
            pin_s2_r <= FGP_ZERO;
            pin_s3_r <= FGP_ZERO;
            pin_val_r <= FGP_ZERO;
            rt_s1_r <= FGP_ZERO;
            rt_s2_r <= FGP_ZERO;
            rt_s3_r <= FGP_ZERO;
            rise_seen_r <= FGP_ZERO;
            ft_s1_r <= FGP_ZERO;
            ft_s2_r <= FGP_ZERO;
            ft_s3_r <= FGP_ZERO;
            fall_seen_r <= FGP_ZERO;
        end
        else
        begin
            pin_s1_r <= pin_in_i;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            pin_val_r <= pin_val_nxt;
            rt_s1_r <= rise_tgl;
            rt_s2_r <= rt_s1_r;
            rt_s3_r <= rt_s2_r;
            rise_seen_r <= rise_seen_nxt;
            ft_s1_r <= fall_tgl;
            ft_s2_r <= ft_s1_r;
            ft_s3_r <= ft_s2_r;
            fall_seen_r <= fall_seen_nxt;
        end
    end

    // A new toggle value seen is one edge event
    // rise or fall event
    assign edge_ev = (rise_seen_nxt ^ rise_seen_r) | (fall_seen_nxt ^ fall_seen_r);
    assign stat_clr = wr_to(acc_i, FGP_SEL_STAT) ? (acc_i.wdata & lanes) : FGP_ZERO;

    // Sticky flags: write one clears, a same-cycle event wins over the clear
    // sticky flags and OR
    assign stat_nxt = (stat_r & ~stat_clr) | edge_ev;
    assign irq_nxt = |stat_nxt;

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            stat_r <= FGP_ZERO;
            irq_r <= 1'b0;
        end
        else
        begin
            stat_r <= stat_nxt;
            irq_r <= irq_nxt;
        end
    end

    // Wake stays combinational on purpose: it must rise with the clock stopped
    // wake from pending edge
    assign wake_o = |((rise_tgl ^ rise_seen_r) | (fall_tgl ^ fall_seen_r)) | irq_r;

    assign rdata_o = rdata_r;
    assign pin_out_o = out_r;
    assign pin_oe_o = dir_r;
    assign irq_o = irq_r;

    // Checks of the access, flag, interrupt and wake behaviour
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_b_i);

    sequence s_full_val_wr;
        acc_i.wr && acc_i.sel == FGP_SEL_VAL && acc_i.be == FGP_ALL_LANES && mask_r == FGP_ZERO;
    endsequence

    sequence s_edge_seen;
        edge_ev != FGP_ZERO;
    endsequence

    a_reset_inputs: assert property ($rose(rst_b_i) |-> pin_oe_o == FGP_ZERO)
        else $error("pins not inputs after reset");
    a_dir_follows: assert property (wr_to(acc_i, FGP_SEL_DIR) && acc_i.be == FGP_ALL_LANES |=>
        pin_oe_o == $past(acc_i.wdata))
        else $error("direction did not follow write");
    a_dir_lanes: assert property (wr_to(acc_i, FGP_SEL_DIR) && acc_i.be != FGP_ALL_LANES |=>
        (pin_oe_o & ~$past(lanes)) == $past(dir_r & ~lanes))
        else $error("unaddressed direction lane changed");
    a_set_bits: assert property (wr_to(acc_i, FGP_SEL_SET) |=>
        pin_out_o == ($past(out_r) | ($past(acc_i.wdata) & $past(port_bits))))
        else $error("set write wrong");
    a_clr_bits: assert property (wr_to(acc_i, FGP_SEL_CLR) |=>
        pin_out_o == ($past(out_r) & ~($past(acc_i.wdata) & $past(port_bits))))
        else $error("clear write wrong");
    a_mask_keep: assert property (acc_i.wr && acc_i.sel == FGP_SEL_VAL |=>
        (pin_out_o & $past(mask_r)) == $past(out_r & mask_r))
        else $error("masked output changed");
    // set and clear respect the mask
    a_mask_setclr: assert property (wr_to(acc_i, FGP_SEL_SET) || wr_to(acc_i, FGP_SEL_CLR) |=>
        (pin_out_o & $past(mask_r)) == $past(out_r & mask_r))
        else $error("masked output changed by set or clear");
    a_lane_keep: assert property (wr_to(acc_i, FGP_SEL_VAL) && acc_i.be != FGP_ALL_LANES |=>
        (pin_out_o & ~$past(lanes)) == $past(out_r & ~lanes))
        else $error("unaddressed lane changed");
    a_full_write: assert property (s_full_val_wr |=> pin_out_o == $past(acc_i.wdata))
        else $error("full write not applied");
    a_read_pin: assert property (acc_i.rd && acc_i.sel == FGP_SEL_VAL |=>
        rdata_o == $past(pin_val_r & ~mask_r))
        else $error("pin read wrong");
    a_rdata_hold: assert property (!acc_i.rd |=> $stable(rdata_o))
        else $error("read data changed without read");
    a_stat_sticky: assert property (!wr_to(acc_i, FGP_SEL_STAT) |=>
        (stat_r & $past(stat_r)) == $past(stat_r))
        else $error("flag lost without clear");
    a_stat_clear: assert property (wr_to(acc_i, FGP_SEL_STAT) && edge_ev == FGP_ZERO |=>
        (stat_r & $past(stat_clr)) == FGP_ZERO)
        else $error("flag not cleared");
    a_event_wins: assert property (s_edge_seen |=> (stat_r & $past(edge_ev)) == $past(edge_ev))
        else $error("edge event lost");
    a_irq_follow: assert property (s_edge_seen |=> irq_o)
        else $error("interrupt missing");
    a_irq_idle: assert property (stat_r == FGP_ZERO |-> !irq_o)
        else $error("interrupt without flag");
    a_wake_irq: assert property (irq_o |-> wake_o)
        else $error("wake missing");

endmodule

// *** sim/fgp_pin_model.sv ***
// Pad model: outside circuitry on the port pins, overridden wherever the port drives
`timescale 1ns/1ns

module fgp_pin_model
(
    input wire logic [31:0] pin_out_i,  // Output latch from the port
    input wire logic [31:0] pin_oe_i,   // Driver enable from the port
    input wire logic [31:0] ext_i,      // Level the outside circuit applies
    output logic [31:0] pin_o           // Level seen at each pad
);
    // pad level
    // A driven pin shows the latch, an undriven pin follows the outside circuit
    assign pin_o = (pin_out_i & pin_oe_i) | (ext_i & ~pin_oe_i);
endmodule

// *** sim/fgp_port_tb_top.sv ***
// Self-checking bench for the fast GPIO port
`timescale 1ns/1ns

module fgp_port_tb_top;
    import fgp_pkg::*;
    logic ref_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic clk_run = 1'b1;
    fgp_acc_t acc = '0;
    logic [31:0] rdata_o, pin_in_i, pin_out_o, pin_oe_o;
    logic [31:0] ext = 32'h0;
    logic irq_o, wake_o;
    logic rd_d = 1'b0;
    logic [31:0] rnd = 32'h1FDC;
    logic [31:0] dir_m, lat_m, m;
    logic [31:0] exp_q[$];
    int num_errors = 0;
    int n_checks = 0;
    int cyc = 0;

    fgp_port i_dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .acc_i(acc), .rdata_o(rdata_o),
        .pin_in_i(pin_in_i), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o), .irq_o(irq_o), .wake_o(wake_o));
    fgp_pin_model i_pins (.pin_out_i(pin_out_o), .pin_oe_i(pin_oe_o), .ext_i(ext), .pin_o(pin_in_i));

    // Clock can be stopped to show edge capture without it
    initial
    begin
        forever
        begin
            #10;
            if (clk_run)
                ref_clk_i = ~ref_clk_i;
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic results();
        $display("Checks %0d, errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] expv);
        n_checks++;
        if (seen !== expv)
        begin
            num_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, expv);
        end
    endtask

    // One-cycle access pulse, always followed by an idle cycle
    task automatic access(input logic w, input logic r, input fgp_sel_t s, input logic [3:0] be,
        input logic [31:0] d);
        @(posedge ref_clk_i);
        acc <= '{wr: w, rd: r, sel: s, be: be, wdata: d};
        @(posedge ref_clk_i);
        acc <= '0;
    endtask

    task automatic wr(input fgp_sel_t s, input logic [3:0] be, input logic [31:0] d);
        access(1'b1, 1'b0, s, be, d);
    endtask

    task automatic rd(input fgp_sel_t s, input logic [31:0] expv);
        exp_q.push_back(expv);
        access(1'b0, 1'b1, s, 4'hF, 32'h0);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask

    // Read data lands one cycle after the strobe; oldest note is compared
    always @(posedge ref_clk_i)
    begin
        if (rd_d && exp_q.size() > 0)
            check(rdata_o, exp_q.pop_front());
        rd_d <= acc.rd;
    end

    // Hang guard, well above the hundred or so cycles the sequence needs
    always @(posedge ref_clk_i)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            num_errors++;
            results();
        end
    end

    initial
    begin
        repeat (3) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        check(pin_oe_o, 32'h0);
        check(pin_out_o, 32'h0);
        // Narrow direction writes touch only their lanes
        rnd = lfsr(rnd);
        wr(FGP_SEL_DIR, 4'h3, rnd);
        dir_m = {16'h0, rnd[15:0]};
        rnd = lfsr(rnd);
        wr(FGP_SEL_DIR, 4'h4, rnd);
        dir_m[23:16] = rnd[23:16];
        rd(FGP_SEL_DIR, dir_m);
        check(pin_oe_o, dir_m);
        // Whole word, then set and clear
        rnd = lfsr(rnd);
        lat_m = rnd;
        wr(FGP_SEL_VAL, 4'hF, lat_m);
        // The latch updates at the edge that ends the write; look once it has settled
        @(negedge ref_clk_i);
        check(pin_out_o, lat_m);
        rnd = lfsr(rnd);
        wr(FGP_SEL_SET, 4'hF, rnd);
        lat_m = lat_m | rnd;
        rnd = lfsr(rnd);
        wr(FGP_SEL_CLR, 4'hF, rnd);
        lat_m = lat_m & ~rnd;
        rd(FGP_SEL_CLR, lat_m);
        // Masked write keeps masked bits, masked read gives zero there
        rnd = lfsr(rnd);
        m = rnd;
        wr(FGP_SEL_MASK, 4'hF, m);
        rnd = lfsr(rnd);
        wr(FGP_SEL_VAL, 4'hF, rnd);
        lat_m = (lat_m & m) | (rnd & ~m);
        rd(FGP_SEL_SET, lat_m & ~m);
        wr(FGP_SEL_SET, 4'hF, 32'hFFFF_FFFF);
        lat_m = lat_m | ~m;
        wr(FGP_SEL_MASK, 4'hF, 32'h0);
        rd(FGP_SEL_SET, lat_m);
        // Byte write to lane one leaves the other lanes alone
        rnd = lfsr(rnd);
        wr(FGP_SEL_VAL, 4'h2, rnd);
        lat_m[15:8] = rnd[15:8];
        rd(FGP_SEL_CLR, lat_m);
        // Live pin read, upper half driven, lower half from outside
        dir_m = 32'hFFFF_0000;
        wr(FGP_SEL_DIR, 4'hF, dir_m);
        rnd = lfsr(rnd);
        ext <= rnd;
        idle(6);
        rd(FGP_SEL_VAL, (lat_m & dir_m) | (rnd & ~dir_m));
        // Edge events: bit0 rise, bit1 fall, bit2 both, bit3 disabled
        wr(FGP_SEL_DIR, 4'hF, 32'h0);
        ext <= 32'h0;
        idle(8);
        wr(FGP_SEL_RISE, 4'hF, 32'h5);
        wr(FGP_SEL_FALL, 4'hF, 32'h6);
        ext <= 32'hF;
        idle(8);
        rd(FGP_SEL_STAT, 32'h5);
        check({31'h0, irq_o}, 32'h1);
        ext <= 32'h0;
        idle(8);
        rd(FGP_SEL_STAT, 32'h7);
        wr(FGP_SEL_STAT, 4'hF, 32'h7);
        idle(2);
        rd(FGP_SEL_STAT, 32'h0);
        check({31'h0, irq_o}, 32'h0);
        // Edge with the clock stopped must wake and be kept
        @(negedge ref_clk_i);
        clk_run = 1'b0;
        #20 check({31'h0, wake_o}, 32'h0);
        #30 ext <= 32'h1;
        #20 check({31'h0, wake_o}, 32'h1);
        clk_run = 1'b1;
        idle(10);
        rd(FGP_SEL_STAT, 32'h1);
        // Let the watcher take the last read before the verdict
        idle(2);
        check(exp_q.size(), 32'h0);
        results();
    end
endmodule
